/* hdl/tfrc_pkg.sv */
// Constants shared by the 16-bit free-running counter block.
// Assumes a single CPU clock domain and a synchronous active-low reset.
package tfrc_pkg;

  // ==========================================================================
  // Counter values
  localparam logic [15:0] TFRC_RESET_COUNT = 16'hFFFC;
  localparam logic [15:0] TFRC_MAX_COUNT   = 16'hFFFF;
  localparam logic [15:0] TFRC_ONE         = 16'h0001;

  // ==========================================================================
  // Clock select codes (divider mapping is a design choice)
  localparam logic [1:0] TFRC_CC_DIV4 = 2'h0;
  localparam logic [1:0] TFRC_CC_DIV8 = 2'h1;
  localparam logic [1:0] TFRC_CC_DIV2 = 2'h2;
  localparam logic [1:0] TFRC_CC_EXT  = 2'h3;

  // ==========================================================================
  // Prescaler
  localparam int          TFRC_PRESC_W    = 3;
  localparam logic [2:0]  TFRC_PRESC_ZERO = 3'h0;
  localparam logic [2:0]  TFRC_PRESC_ONE  = 3'h1;
  localparam logic [2:0]  TFRC_MASK_DIV2  = 3'h1;
  localparam logic [2:0]  TFRC_MASK_DIV4  = 3'h3;
  localparam logic [2:0]  TFRC_MASK_DIV8  = 3'h7;

  // ==========================================================================
  // Read sequence states (Gray coded)
  typedef enum logic [1:0] {
    TFRC_SEQ_IDLE = 2'b00,
    TFRC_SEQ_HELD = 2'b01
  } tfrc_seq_t;

endpackage

/* hdl/tfrc_edge_detect.sv */
// Edge detector for the external clock pin.
// Assumes the pin is already synchronous to I_CLK.
`timescale 1ns/10ps
module tfrc_edge_detect (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_pin,
  input  wire logic i_rise_sel,
  output logic      o_edge
);

  // ==========================================================================
  // Pin history
  logic pin_reg;
  logic rise_w;
  logic fall_w;

  // Reset to one so an unbonded pin (held high) sees no false edge
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pin_reg <= 1'b1;
    end else begin
      pin_reg <= i_pin;
    end
  end

  assign rise_w = i_pin & ~pin_reg;
  assign fall_w = ~i_pin & pin_reg;
  assign o_edge = i_rise_sel ? rise_w : fall_w;

endmodule

/* hdl/tfrc_counter.sv */
// 16-bit free-running up counter with coherent byte reads and overflow flag.
// Assumes byte access strobes are one-cycle pulses synchronous to I_CLK.
`timescale 1ns/10ps
module tfrc_counter #(
  parameter logic [1:0] P_CC_DIV2 = tfrc_pkg::TFRC_CC_DIV2,
  parameter logic [1:0] P_CC_DIV4 = tfrc_pkg::TFRC_CC_DIV4,
  parameter logic [1:0] P_CC_DIV8 = tfrc_pkg::TFRC_CC_DIV8,
  parameter bit         P_EXT_BONDED = 1'b1
) (
  input  wire logic       I_CLK,
  input  wire logic       I_NRST,
  input  wire logic [1:0] I_CLOCK_SELECT,
  input  wire logic       I_EXT_EDGE_SELECT,
  input  wire logic       I_EXT_CLOCK_PIN,
  input  wire logic       I_OVERFLOW_IRQ_ENABLE,
  input  wire logic       I_CPU_IRQ_MASK,
  input  wire logic       I_HALT,
  input  wire logic       I_WAIT,
  input  wire logic       I_RD_HIGH,
  input  wire logic       I_RD_LOW,
  input  wire logic       I_WR_LOW,
  input  wire logic       I_RD_ALT_HIGH,
  input  wire logic       I_RD_ALT_LOW,
  input  wire logic       I_WR_ALT_LOW,
  input  wire logic       I_RD_STATUS,
  output logic [7:0]      O_RD_DATA,
  output logic            O_OVERFLOW_FLAG,
  output logic            O_TIMER_IRQ,
  output logic [15:0]     O_COUNTER_VALUE
);

  // ==========================================================================
  // Declarations
  logic [15:0]                       count_reg;
  logic [15:0]                       count_next;
  logic [tfrc_pkg::TFRC_PRESC_W-1:0] presc_reg;
  logic [tfrc_pkg::TFRC_PRESC_W-1:0] presc_next;
  logic [tfrc_pkg::TFRC_PRESC_W-1:0] presc_mask;
  logic [7:0]                        held_low_reg;
  tfrc_pkg::tfrc_seq_t               seq_reg;
  tfrc_pkg::tfrc_seq_t               seq_next;
  logic                              flag_reg;
  logic                              flag_next;
  logic                              armed_reg;
  logic                              armed_next;
  logic                              irq_reg;
  logic [7:0]                        rd_data_reg;
  logic [7:0]                        rd_data_next;
  logic                              ext_pin_w;
  logic                              ext_edge_w;
  logic                              ext_sel_w;
  logic                              presc_tick_w;
  logic                              tick_w;
  logic                              force_w;
  logic                              rollover_w;
  logic                              any_high_w;
  logic                              any_low_rd_w;
  logic                              clear_w;
  logic [3:0]                        gap_reg;
  logic                              gap_ok_reg;
  logic [1:0]                        sel_reg;
  logic [3:0]                        div_w;

  // ==========================================================================
  // Clock source selection
  assign ext_pin_w = P_EXT_BONDED ? I_EXT_CLOCK_PIN : 1'b1;
  assign ext_sel_w = (I_CLOCK_SELECT == tfrc_pkg::TFRC_CC_EXT);

  tfrc_edge_detect u_edge (
    .i_clk      (I_CLK),
    .i_nrst     (I_NRST),
    .i_pin      (ext_pin_w),
    .i_rise_sel (I_EXT_EDGE_SELECT),
    .o_edge     (ext_edge_w)
  );

  assign presc_mask = (I_CLOCK_SELECT == P_CC_DIV2) ? tfrc_pkg::TFRC_MASK_DIV2 :
                      (I_CLOCK_SELECT == P_CC_DIV4) ? tfrc_pkg::TFRC_MASK_DIV4 :
                      tfrc_pkg::TFRC_MASK_DIV8;
  assign presc_tick_w = ((presc_reg & presc_mask) == presc_mask);
  // Halt freezes prescaler and counting, though a low byte write still forces the counter; wait has no effect
  assign tick_w = ~I_HALT & (ext_sel_w ? ext_edge_w : presc_tick_w);
  assign presc_next = I_HALT ? presc_reg :
                      presc_reg + tfrc_pkg::TFRC_PRESC_ONE;

  // ==========================================================================
  // Counter update
  assign force_w    = I_WR_LOW | I_WR_ALT_LOW;
  assign rollover_w = tick_w & (count_reg == tfrc_pkg::TFRC_MAX_COUNT);
  assign count_next = force_w ? tfrc_pkg::TFRC_RESET_COUNT :
                      tick_w  ? count_reg + tfrc_pkg::TFRC_ONE :
                      count_reg;

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      count_reg <= tfrc_pkg::TFRC_RESET_COUNT;
      presc_reg <= tfrc_pkg::TFRC_PRESC_ZERO;
    end else begin
      count_reg <= count_next;
      presc_reg <= presc_next;
    end
  end

  // ==========================================================================
  // Coherent read sequence
  assign any_high_w   = I_RD_HIGH | I_RD_ALT_HIGH;
  assign any_low_rd_w = I_RD_LOW | I_RD_ALT_LOW;
  assign seq_next = any_low_rd_w ? tfrc_pkg::TFRC_SEQ_IDLE :
                    any_high_w   ? tfrc_pkg::TFRC_SEQ_HELD :
                    seq_reg;

  assign rd_data_next = any_high_w ? count_reg[15:8] :
                        any_low_rd_w ? ((seq_reg == tfrc_pkg::TFRC_SEQ_HELD) ?
                                        held_low_reg : count_reg[7:0]) :
                        rd_data_reg;

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      seq_reg      <= tfrc_pkg::TFRC_SEQ_IDLE;
      held_low_reg <= 8'h00;
      rd_data_reg  <= 8'h00;
    end else begin
      seq_reg     <= seq_next;
      rd_data_reg <= rd_data_next;
      // Only the first high read of a sequence captures
      if (any_high_w && seq_reg == tfrc_pkg::TFRC_SEQ_IDLE) begin
        held_low_reg <= count_reg[7:0];
      end
    end
  end

  // ==========================================================================
  // Overflow flag, two-step clear, interrupt
  // Status read arms the clear only when the flag is seen set
  assign armed_next = clear_w ? 1'b0 :
                      (I_RD_STATUS & flag_reg) ? 1'b1 : armed_reg;
  // Alternate view accesses never take part in clearing
  assign clear_w   = armed_reg & (I_RD_LOW | I_WR_LOW);
  // Set wins over a clear in the same cycle
  assign flag_next = rollover_w ? 1'b1 : (clear_w ? 1'b0 : flag_reg);

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      flag_reg  <= 1'b0;
      armed_reg <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      flag_reg  <= flag_next;
      armed_reg <= armed_next;
      irq_reg   <= flag_next & I_OVERFLOW_IRQ_ENABLE & ~I_CPU_IRQ_MASK;
    end
  end

  // ==========================================================================
  // Outputs
  assign O_RD_DATA       = rd_data_reg;
  assign O_OVERFLOW_FLAG = flag_reg;
  assign O_TIMER_IRQ     = irq_reg;
  assign O_COUNTER_VALUE = count_reg;

  // ==========================================================================
  // Assertion helpers
  // Spacing of internal ticks; a select change or halt restarts the measure,
  // since the free-running prescaler leaves one short first period
  assign div_w = (I_CLOCK_SELECT == P_CC_DIV2) ? {1'b0, tfrc_pkg::TFRC_MASK_DIV2} + 4'h1 :
                 (I_CLOCK_SELECT == P_CC_DIV4) ? {1'b0, tfrc_pkg::TFRC_MASK_DIV4} + 4'h1 :
                 {1'b0, tfrc_pkg::TFRC_MASK_DIV8} + 4'h1;

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      gap_reg    <= 4'h0;
      gap_ok_reg <= 1'b0;
      sel_reg    <= tfrc_pkg::TFRC_CC_EXT;
    end else begin
      sel_reg <= I_CLOCK_SELECT;
      if (I_CLOCK_SELECT != sel_reg || I_HALT) begin
        gap_reg    <= 4'h0;
        gap_ok_reg <= 1'b0;
      end else if (presc_tick_w) begin
        gap_reg    <= 4'h1;
        gap_ok_reg <= 1'b1;
      end else if (gap_reg != 4'hF) begin
        gap_reg <= gap_reg + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Assertions
  AST_RESET_VALUE: assert property (@(posedge I_CLK)
    !I_NRST |=> count_reg == tfrc_pkg::TFRC_RESET_COUNT)
    else $error("Counter not FFFC after reset");

  AST_WRITE_FORCE: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (I_WR_LOW || I_WR_ALT_LOW) |=> count_reg == tfrc_pkg::TFRC_RESET_COUNT)
    else $error("Low byte write did not force FFFC");

  AST_ROLLOVER_FLAG: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    ($past(count_reg) == tfrc_pkg::TFRC_MAX_COUNT && count_reg == 16'h0000)
    |-> flag_reg)
    else $error("Rollover did not set overflow flag");

  AST_HALT_FREEZE: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (I_HALT && !force_w) |=> $stable(count_reg))
    else $error("Counter moved in halt");

  AST_HELD_STABLE: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (seq_reg == tfrc_pkg::TFRC_SEQ_HELD && !any_low_rd_w) |=> $stable(held_low_reg))
    else $error("Held low byte changed mid sequence");

  AST_HELD_RETURN: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (seq_reg == tfrc_pkg::TFRC_SEQ_HELD && I_RD_LOW && !I_RD_HIGH && !I_RD_ALT_HIGH)
    |=> O_RD_DATA == $past(held_low_reg))
    else $error("Low read did not return held byte");

  AST_LIVE_LOW: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (seq_reg == tfrc_pkg::TFRC_SEQ_IDLE && I_RD_ALT_LOW && !any_high_w)
    |=> O_RD_DATA == $past(count_reg[7:0]))
    else $error("Live low read wrong");

  AST_ALT_NO_CLEAR: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (flag_reg && !I_RD_LOW && !I_WR_LOW) |=> flag_reg)
    else $error("Flag cleared without primary access");

  AST_IRQ_GATE: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (flag_reg && I_OVERFLOW_IRQ_ENABLE && !I_CPU_IRQ_MASK && !clear_w) |=> O_TIMER_IRQ)
    else $error("Interrupt not raised");

  AST_EXT_COUNT: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (ext_sel_w && !ext_edge_w && !force_w) |=> $stable(count_reg))
    else $error("Counter moved without external edge");

  // ==========================================================================
  // Counting and clock source

  AST_DIV_PERIOD: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (presc_tick_w && gap_ok_reg && !ext_sel_w && !I_HALT) |-> gap_reg == div_w)
    else $error("Internal tick period wrong");

  AST_COUNT_STEP: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (tick_w && !force_w) |=> count_reg == $past(count_reg) + tfrc_pkg::TFRC_ONE)
    else $error("Counter did not step by one");

  AST_NO_TICK_HOLD: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (!tick_w && !force_w) |=> $stable(count_reg))
    else $error("Counter moved without a tick");

  AST_ALT_WRITE_FORCE: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    I_WR_ALT_LOW |=> count_reg == tfrc_pkg::TFRC_RESET_COUNT)
    else $error("Alternate low write did not force FFFC");

  AST_ROLL_ZERO: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (rollover_w && !force_w) |=> count_reg == 16'h0000)
    else $error("Rollover did not reach zero");

  AST_EXT_TICK: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (ext_sel_w && ext_edge_w && !I_HALT && !force_w)
    |=> count_reg == $past(count_reg) + tfrc_pkg::TFRC_ONE)
    else $error("External edge did not advance counter");

  AST_HALT_PRESC: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    I_HALT |=> $stable(presc_reg))
    else $error("Prescaler moved in halt");

  AST_PRESC_RUN: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !I_HALT |=> presc_reg == $past(presc_reg) + tfrc_pkg::TFRC_PRESC_ONE)
    else $error("Prescaler did not free-run");

  // ==========================================================================
  // Coherent reads

  AST_HIGH_DATA: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    any_high_w |=> O_RD_DATA == $past(count_reg[15:8]))
    else $error("High byte read wrong");

  AST_CAPTURE: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (any_high_w && seq_reg == tfrc_pkg::TFRC_SEQ_IDLE)
    |=> held_low_reg == $past(count_reg[7:0]))
    else $error("High read did not capture low byte");

  AST_SEQ_START: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (any_high_w && !any_low_rd_w) |=> seq_reg == tfrc_pkg::TFRC_SEQ_HELD)
    else $error("High read did not open sequence");

  AST_NO_RECAPTURE: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (any_high_w && seq_reg == tfrc_pkg::TFRC_SEQ_HELD) |=> $stable(held_low_reg))
    else $error("Repeated high read refreshed held byte");

  AST_SEQ_END: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    any_low_rd_w |=> seq_reg == tfrc_pkg::TFRC_SEQ_IDLE)
    else $error("Low read did not end sequence");

  AST_LIVE_PRIMARY: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (seq_reg == tfrc_pkg::TFRC_SEQ_IDLE && I_RD_LOW && !any_high_w)
    |=> O_RD_DATA == $past(count_reg[7:0]))
    else $error("Live primary low read wrong");

  AST_RD_HOLD: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (!any_high_w && !any_low_rd_w) |=> $stable(O_RD_DATA))
    else $error("Read data changed without a read");

  // ==========================================================================
  // Flag and interrupt

  AST_FLAG_HOLD_LOW: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (!flag_reg && !rollover_w) |=> !flag_reg)
    else $error("Flag set without rollover");

  AST_SET_WINS: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    rollover_w |=> flag_reg)
    else $error("Rollover lost to a clear");

  AST_CLEAR_NEEDS_ARM: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (flag_reg && !armed_reg) |=> flag_reg)
    else $error("Flag cleared without status read");

  AST_CLEAR_TWO_STEP: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (clear_w && !rollover_w) |=> !flag_reg)
    else $error("Flag not cleared after both steps");

  AST_ARM_ON_STATUS: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (I_RD_STATUS && flag_reg && !clear_w) |=> armed_reg)
    else $error("Status read did not arm the clear");

  AST_ARM_NEEDS_FLAG: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (I_RD_STATUS && !flag_reg && !armed_reg) |=> !armed_reg)
    else $error("Status read armed with flag clear");

  AST_IRQ_MASKED: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    I_CPU_IRQ_MASK |=> !O_TIMER_IRQ)
    else $error("Interrupt raised while masked");

  AST_IRQ_DISABLED: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !I_OVERFLOW_IRQ_ENABLE |=> !O_TIMER_IRQ)
    else $error("Interrupt raised while disabled");

  AST_IRQ_NEEDS_FLAG: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    O_TIMER_IRQ |-> O_OVERFLOW_FLAG)
    else $error("Interrupt without overflow flag");

  COV_ROLLOVER: cover property (@(posedge I_CLK) disable iff (!I_NRST) rollover_w);
  COV_HALT:     cover property (@(posedge I_CLK) disable iff (!I_NRST) I_HALT && force_w);
  COV_CLEAR:    cover property (@(posedge I_CLK) disable iff (!I_NRST) clear_w);
  COV_SEQ:      cover property (@(posedge I_CLK) disable iff (!I_NRST)
    any_high_w ##[1:20] I_RD_LOW);
  COV_EXT:      cover property (@(posedge I_CLK) disable iff (!I_NRST) ext_sel_w && tick_w);

endmodule

/* testbench/tfrc_ext_clk_model.sv */
// External clock source that drives the counter's clock pin.
// Assumes the bench pulses i_go for one cycle, then waits on o_busy.
`timescale 1ns/10ps
module tfrc_ext_clk_model (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [3:0] i_n,
  input  wire logic [3:0] i_half,
  output logic            o_pin,
  output logic            o_busy
);
  // ==========================================================================
  // Pulse train, pin idles low between trains
  logic [4:0] edges_reg;
  logic [3:0] tick_reg;
  logic [3:0] half_w;
  initial begin
    o_pin     = 1'b0;
    edges_reg = 5'h00;
    tick_reg  = 4'h0;
  end
  // Half period of two or more keeps active edges at least four clocks apart
  assign half_w = (i_half < 4'h2) ? 4'h2 : i_half;
  assign o_busy = (edges_reg != 5'h00);
  always @(posedge i_clk) begin
    if (edges_reg == 5'h00) begin
      if (i_go) begin
        edges_reg <= {i_n, 1'b0};
        tick_reg  <= half_w;
      end
    end else if (tick_reg == 4'h1) begin
      o_pin     <= ~o_pin;
      edges_reg <= edges_reg - 5'h01;
      tick_reg  <= half_w;
    end else begin
      tick_reg <= tick_reg - 4'h1;
    end
  end
endmodule

/* testbench/test_tfrc_counter.sv */
// Self-checking bench for the free-running counter.
// Assumes the external clock model drives the pin; inputs change at falling edges.
`timescale 1ns/10ps
module test_tfrc_counter;
  logic        I_CLK, I_NRST, I_EXT_EDGE_SELECT, I_OVERFLOW_IRQ_ENABLE, I_CPU_IRQ_MASK;
  logic        I_HALT, I_WAIT, go, busy, pin, rd_seen, O_OVERFLOW_FLAG, O_TIMER_IRQ;
  logic [1:0]  I_CLOCK_SELECT;
  logic [6:0]  stb;
  logic [3:0]  n_pulse, half;
  logic [7:0]  O_RD_DATA;
  logic [15:0] O_COUNTER_VALUE;
  logic [31:0] seed;
  logic [7:0]  exp_q[$];
  int          errors, n_compared, c;

  // ==========================================================================
  // Design and far side
  tfrc_counter i_dut (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_CLOCK_SELECT(I_CLOCK_SELECT),
    .I_EXT_EDGE_SELECT(I_EXT_EDGE_SELECT), .I_EXT_CLOCK_PIN(pin),
    .I_OVERFLOW_IRQ_ENABLE(I_OVERFLOW_IRQ_ENABLE), .I_CPU_IRQ_MASK(I_CPU_IRQ_MASK),
    .I_HALT(I_HALT), .I_WAIT(I_WAIT), .I_RD_HIGH(stb[0]), .I_RD_LOW(stb[1]),
    .I_WR_LOW(stb[2]), .I_RD_ALT_HIGH(stb[3]), .I_RD_ALT_LOW(stb[4]), .I_WR_ALT_LOW(stb[5]),
    .I_RD_STATUS(stb[6]), .O_RD_DATA(O_RD_DATA), .O_OVERFLOW_FLAG(O_OVERFLOW_FLAG),
    .O_TIMER_IRQ(O_TIMER_IRQ), .O_COUNTER_VALUE(O_COUNTER_VALUE));
  tfrc_ext_clk_model i_ext (.i_clk(I_CLK), .i_go(go), .i_n(n_pulse), .i_half(half),
    .o_pin(pin), .o_busy(busy));

  initial begin
    I_CLK = 1'b0;
    forever #20 I_CLK = ~I_CLK;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One strobe per access; a gap cycle keeps strobes from merging
  task automatic acc(input int idx, input logic [7:0] exp);
    @(negedge I_CLK);
    stb = 7'h01 << idx;
    if (idx == 0 || idx == 1 || idx == 3 || idx == 4) exp_q.push_back(exp);
    @(negedge I_CLK);
    stb = 7'h00;
  endtask
  task automatic pulses(input logic [3:0] n);
    @(negedge I_CLK);
    n_pulse = n;
    half    = 4'h2 + {2'h0, seed[9:8]};
    go      = 1'b1;
    @(negedge I_CLK);
    go = 1'b0;
    c  = 0;
    while (busy === 1'b1 && c < 200) begin
      @(negedge I_CLK);
      c++;
    end
    repeat (3) @(negedge I_CLK);
  endtask
  // Skips the first change, since a new select may leave a short period
  task automatic per(input logic [1:0] cs, input logic [15:0] n);
    logic [15:0] v;
    I_CLOCK_SELECT = cs;
    repeat (12) @(negedge I_CLK);
    for (int k = 0; k < 2; k++) begin
      v = O_COUNTER_VALUE;
      c = 0;
      while (O_COUNTER_VALUE === v && c < 20) begin
        @(negedge I_CLK);
        c++;
      end
    end
    chk("count period", 16'(c), n);
  endtask

  // ==========================================================================
  // Result monitor and random wait mode
  always @(posedge I_CLK) rd_seen <= stb[0] | stb[1] | stb[3] | stb[4];
  always @(negedge I_CLK) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) chk("read data", 16'(O_RD_DATA), 16'(exp_q.pop_front()));
    seed   = xs(seed);
    I_WAIT = seed[0];
  end
  initial begin
    repeat (5000) @(posedge I_CLK);
    errors++;
    close_out();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {I_NRST, stb, go, n_pulse, half, I_HALT, I_WAIT, rd_seen, I_CPU_IRQ_MASK} = '0;
    {I_EXT_EDGE_SELECT, I_OVERFLOW_IRQ_ENABLE} = 2'h3;
    I_CLOCK_SELECT = tfrc_pkg::TFRC_CC_EXT;
    seed = 32'h55F4D3F5;
    errors = 0;
    n_compared = 0;
    repeat (3) @(negedge I_CLK);
    I_NRST = 1'b1;
    chk("reset count", O_COUNTER_VALUE, tfrc_pkg::TFRC_RESET_COUNT);
    per(tfrc_pkg::TFRC_CC_DIV2, 16'h0002);
    per(tfrc_pkg::TFRC_CC_DIV4, 16'h0004);
    per(tfrc_pkg::TFRC_CC_DIV8, 16'h0008);
    chk("flag after wrap", 16'(O_OVERFLOW_FLAG), 16'h0001);
    I_HALT = 1'b1;
    I_CLOCK_SELECT = tfrc_pkg::TFRC_CC_DIV2;
    acc(5, 8'h00);
    repeat (8) @(negedge I_CLK);
    chk("halt count", O_COUNTER_VALUE, 16'hFFFC);
    acc(6, 8'h00);
    acc(1, 8'hFC);
    chk("flag cleared", 16'(O_OVERFLOW_FLAG), 16'h0000);
    I_CLOCK_SELECT = tfrc_pkg::TFRC_CC_EXT;
    I_HALT = 1'b0;
    acc(0, 8'hFF);
    pulses(4'h2);
    acc(3, 8'hFF);
    acc(1, 8'hFC);
    acc(4, 8'hFE);
    chk("ext count", O_COUNTER_VALUE, 16'hFFFE);
    I_EXT_EDGE_SELECT = 1'b0;
    pulses(4'h2);
    chk("falling count", O_COUNTER_VALUE, 16'h0000);
    chk("ext wrap flag", 16'(O_OVERFLOW_FLAG), 16'h0001);
    chk("irq on", 16'(O_TIMER_IRQ), 16'h0001);
    I_CPU_IRQ_MASK = 1'b1;
    repeat (2) @(negedge I_CLK);
    chk("irq masked", 16'(O_TIMER_IRQ), 16'h0000);
    I_CPU_IRQ_MASK = 1'b0;
    repeat (2) @(negedge I_CLK);
    chk("irq pending", 16'(O_TIMER_IRQ), 16'h0001);
    acc(4, 8'h00);
    acc(1, 8'h00);
    chk("flag kept", 16'(O_OVERFLOW_FLAG), 16'h0001);
    acc(6, 8'h00);
    acc(2, 8'h00);
    repeat (2) @(negedge I_CLK);
    chk("flag and irq", 16'({O_OVERFLOW_FLAG, O_TIMER_IRQ}), 16'h0000);
    chk("write count", O_COUNTER_VALUE, 16'hFFFC);
    close_out();
  end
endmodule
